// ==== rtl/p23g_bank_if.sv ====
// control and status bundle between the register block and one pin bank
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface p23g_bank_if #(parameter int W = 8);
  logic [W-1:0] dir;
  logic [W-1:0] data;
  logic [W-1:0] od_sel;
  logic [W-1:0] alt_en;
  logic [W-1:0] alt_oe;
  logic [W-1:0] alt_out;
  logic [W-1:0] out_d;
  logic [W-1:0] oe_d;
  logic [W-1:0] level;
  logic [W-1:0] rd;
  modport ctl (output dir, data, od_sel, alt_en, alt_oe, alt_out, input out_d, oe_d, level, rd);
  modport bank (input dir, data, od_sel, alt_en, alt_oe, alt_out, output out_d, oe_d, level, rd);
endinterface

`default_nettype wire

// ==== rtl/p23g_gpio.sv ====
// two-port gpio block: five-pin port a shared with the serial unit, eight-pin port b
// assumes an apb3 master on pclk; serial unit signals are on pclk; pins are asynchronous
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

`include "p23g_regs.svh"

module p23g_gpio #(
  parameter int PA_W = `P23G_PA_W,
  parameter int PB_W = `P23G_PB_W
) (
  input wire logic pclk, // bus clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction, 1 = write
  input wire logic [`P23G_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [PA_W-1:0] pa_pin_in, // port a pin levels
  output logic [PA_W-1:0] pa_pin_out, // port a output values
  output logic [PA_W-1:0] pa_pin_oe, // port a output enables, high drives
  input wire logic [PB_W-1:0] pb_pin_in, // port b pin levels
  output logic [PB_W-1:0] pb_pin_out, // port b output values
  output logic [PB_W-1:0] pb_pin_oe, // port b output enables, high drives
  input wire logic ser_tx_data, // serial transmit data
  input wire logic ser_clk_out, // serial clock from the serial unit
  output logic ser_rx_data, // synchronised receive pin
  output logic ser_clk_in, // synchronised serial clock pin
  output logic ser_rx_on, // receiver enable to the serial unit
  output logic ser_clk_source_hi, // external clock select to the serial unit
  output logic ser_clk_source_lo, // clock output select to the serial unit
  output logic ser_sync_mode, // synchronous mode to the serial unit
  output logic ser_tx_sel // transmit pin select to the serial unit
);
  p23g_bank_if #(.W(PA_W)) pa_if ();
  p23g_bank_if #(.W(PB_W)) pb_if ();

  logic [PA_W-1:0] pa_dir_q;
  logic [PA_W-1:0] pa_data_q;
  logic [`P23G_DRIVE_OD_W-1:0] od_sel_q;
  logic [PB_W-1:0] pb_dir_q;
  logic [PB_W-1:0] pb_data_q;
  p23g_pkg::p23g_ser_cfg_t cfg_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [PA_W-1:0] pa_out_q;
  logic [PA_W-1:0] pa_oe_q;
  logic [PB_W-1:0] pb_out_q;
  logic [PB_W-1:0] pb_oe_q;

  // bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire wr_en = access & pwrite;
  wire hit_pa_dir = paddr == `P23G_ADDR_PA_DIR;
  wire hit_pa_data = paddr == `P23G_ADDR_PA_DATA;
  wire hit_drive = paddr == `P23G_ADDR_PA_DRIVE;
  wire hit_pb_dir = paddr == `P23G_ADDR_PB_DIR;
  wire hit_pb_data = paddr == `P23G_ADDR_PB_DATA;
  wire hit_cfg = paddr == `P23G_ADDR_SER_CFG;
  wire mapped = hit_pa_dir | hit_pa_data | hit_drive | hit_pb_dir | hit_pb_data | hit_cfg;

  // read views; direction registers are write-only and read as zero
  wire [`P23G_REG_W-1:0] pa_data_rd = `P23G_PA_DATA_RSV_ONES | `P23G_REG_W'(pa_if.rd);
  wire [`P23G_REG_W-1:0] drive_rd = `P23G_DRIVE_FIXED | (`P23G_REG_W'(od_sel_q) << `P23G_DRIVE_OD_LSB);
  wire [`P23G_REG_W-1:0] pb_data_rd = `P23G_REG_W'(pb_if.rd);
  wire [`P23G_REG_W-1:0] cfg_rd = `P23G_REG_W'(cfg_q);
  wire [`P23G_REG_W-1:0] rd_mux = hit_pa_data ? pa_data_rd :
                                  hit_drive ? drive_rd :
                                  hit_pb_data ? pb_data_rd :
                                  hit_cfg ? cfg_rd : `P23G_RST_BYTE;

  // serial pin ownership on port a
  wire sck_in_mode = cfg_q.clk_source_hi;
  wire sck_out_mode = ~cfg_q.clk_source_hi & (cfg_q.clk_source_lo | cfg_q.sync_mode);
  logic [PA_W-1:0] pa_alt_en;
  logic [PA_W-1:0] pa_alt_oe;
  logic [PA_W-1:0] pa_alt_out;

  always_comb begin
    pa_alt_en = '0;
    pa_alt_oe = '0;
    pa_alt_out = '0;
    pa_alt_en[`P23G_PIN_TX] = cfg_q.tx_sel;
    pa_alt_oe[`P23G_PIN_TX] = 1'b1;
    pa_alt_out[`P23G_PIN_TX] = ser_tx_data;
    pa_alt_en[`P23G_PIN_RX] = cfg_q.rx_on;
    pa_alt_en[`P23G_PIN_SCK] = sck_in_mode | sck_out_mode;
    pa_alt_oe[`P23G_PIN_SCK] = sck_out_mode;
    pa_alt_out[`P23G_PIN_SCK] = ser_clk_out;
  end

  assign pa_if.dir = pa_dir_q;
  assign pa_if.data = pa_data_q;
  // only pins 4 and 3 have the open-drain option
  assign pa_if.od_sel = PA_W'(od_sel_q) << `P23G_DRIVE_OD_LSB;
  assign pa_if.alt_en = pa_alt_en;
  assign pa_if.alt_oe = pa_alt_oe;
  assign pa_if.alt_out = pa_alt_out;

  assign pb_if.dir = pb_dir_q;
  assign pb_if.data = pb_data_q;
  assign pb_if.od_sel = '0;
  assign pb_if.alt_en = '0;
  assign pb_if.alt_oe = '0;
  assign pb_if.alt_out = '0;

  p23g_pin_bank #(.W(PA_W)) u_pa_bank (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in(pa_pin_in),
    .b(pa_if.bank)
  );

  p23g_pin_bank #(.W(PB_W)) u_pb_bank (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in(pb_pin_in),
    .b(pb_if.bank)
  );

  // one write strobe per register
  wire wr_pa_dir = wr_en & hit_pa_dir;
  wire wr_pa_data = wr_en & hit_pa_data;
  wire wr_drive = wr_en & hit_drive;
  wire wr_pb_dir = wr_en & hit_pb_dir;
  wire wr_pb_data = wr_en & hit_pb_data;
  wire wr_cfg = wr_en & hit_cfg;

  // apb answer: one wait-free access phase after setup
  wire pready_d = setup;
  // an unmapped address still completes, flagged on the error line
  wire pslverr_d = setup & ~mapped;
  // read data is taken at setup; a pin change during access shows on the next read
  wire [31:0] prdata_d = setup ? {`P23G_RDATA_PAD, rd_mux} : 32'h0000_0000;

  // next register values; an unwritten register holds
  wire [PA_W-1:0] pa_dir_d = wr_pa_dir ? pwdata[PA_W-1:0] : pa_dir_q;
  wire [PA_W-1:0] pa_data_d = wr_pa_data ? pwdata[PA_W-1:0] : pa_data_q;
  // only the two open-drain bits are stored; the rest are fixed
  wire [`P23G_DRIVE_OD_W-1:0] od_sel_d = wr_drive ?
    pwdata[`P23G_DRIVE_OD_LSB +: `P23G_DRIVE_OD_W] : od_sel_q;
  wire [PB_W-1:0] pb_dir_d = wr_pb_dir ? pwdata[PB_W-1:0] : pb_dir_q;
  wire [PB_W-1:0] pb_data_d = wr_pb_data ? pwdata[PB_W-1:0] : pb_data_q;
  // config bits map straight onto the struct, transmit select at bit 0
  p23g_pkg::p23g_ser_cfg_t cfg_d;
  assign cfg_d = wr_cfg ? p23g_pkg::p23g_ser_cfg_t'(pwdata[`P23G_SER_CFG_W-1:0]) : cfg_q;

  // pin drivers registered so pins never glitch on decode changes
  wire [PA_W-1:0] pa_out_d = pa_if.out_d;
  wire [PA_W-1:0] pa_oe_d = pa_if.oe_d;
  wire [PB_W-1:0] pb_out_d = pb_if.out_d;
  wire [PB_W-1:0] pb_oe_d = pb_if.oe_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else if (ce) begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      prdata_q <= prdata_d;
    end
  end

  // port a registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_dir_q <= '0;
    end else if (ce) begin
      pa_dir_q <= pa_dir_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_data_q <= '0;
    end else if (ce) begin
      pa_data_q <= pa_data_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_sel_q <= '0;
    end else if (ce) begin
      od_sel_q <= od_sel_d;
    end
  end

  // port b registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_dir_q <= '0;
    end else if (ce) begin
      pb_dir_q <= pb_dir_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_data_q <= '0;
    end else if (ce) begin
      pb_data_q <= pb_data_d;
    end
  end

  // serial pin configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
    end else if (ce) begin
      cfg_q <= cfg_d;
    end
  end

  // pin driver flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out_q <= '0;
    end else if (ce) begin
      pa_out_q <= pa_out_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_oe_q <= '0;
    end else if (ce) begin
      pa_oe_q <= pa_oe_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_out_q <= '0;
    end else if (ce) begin
      pb_out_q <= pb_out_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_oe_q <= '0;
    end else if (ce) begin
      pb_oe_q <= pb_oe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pa_pin_out = pa_out_q;
  assign pa_pin_oe = pa_oe_q;
  assign pb_pin_out = pb_out_q;
  assign pb_pin_oe = pb_oe_q;
  // receive and clock inputs come from the second synchroniser stage
  assign ser_rx_data = pa_if.level[`P23G_PIN_RX];
  assign ser_clk_in = pa_if.level[`P23G_PIN_SCK];
  assign ser_rx_on = cfg_q.rx_on;
  assign ser_clk_source_hi = cfg_q.clk_source_hi;
  assign ser_clk_source_lo = cfg_q.clk_source_lo;
  assign ser_sync_mode = cfg_q.sync_mode;
  assign ser_tx_sel = cfg_q.tx_sel;
endmodule

`default_nettype wire

// ==== rtl/p23g_pin_bank.sv ====
// one bank of gpio pins: input synchroniser, drive decision and read-back select
// assumes pin inputs are asynchronous to pclk; the caller registers out_d and oe_d
`timescale 1ns/100ps
`default_nettype none

module p23g_pin_bank #(
  parameter int W = 8
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes the synchroniser
  input wire logic [W-1:0] pin_in, // raw pin levels
  p23g_bank_if.bank b // register side
);
  logic [W-1:0] meta_q;
  logic [W-1:0] level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      level_q <= '0;
    end else if (ce) begin
      meta_q <= pin_in;
      level_q <= meta_q;
    end
  end

  assign b.level = level_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // open drain: a one releases the pin rather than driving it high
      wire gpio_oe = b.dir[i] & ~(b.od_sel[i] & b.data[i]);
      assign b.oe_d[i] = b.alt_en[i] ? b.alt_oe[i] : gpio_oe;
      assign b.out_d[i] = b.alt_en[i] ? b.alt_out[i] : b.data[i];
      assign b.rd[i] = b.dir[i] ? b.data[i] : level_q[i];
    end
  endgenerate
endmodule

`default_nettype wire

// ==== rtl/p23g_pkg.sv ====
// types shared by the two-port gpio block
// assumes p23g_regs.svh supplies the widths
`include "p23g_regs.svh"

package p23g_pkg;
  typedef logic [`P23G_REG_W-1:0] p23g_byte_t;
  typedef logic [`P23G_ADDR_W-1:0] p23g_addr_t;
  typedef struct packed {
    logic sync_mode;
    logic clk_source_lo;
    logic clk_source_hi;
    logic rx_on;
    logic tx_sel;
  } p23g_ser_cfg_t;
endpackage

// ==== rtl/p23g_regs.svh ====
// register map, field positions and fixed read values of the two-port gpio block
// assumes a 32-bit apb slave with one aligned word per register
`ifndef P23G_REGS_SVH
`define P23G_REGS_SVH

`define P23G_ADDR_W 8
`define P23G_ADDR_PA_DIR 8'h00
`define P23G_ADDR_PA_DATA 8'h04
`define P23G_ADDR_PA_DRIVE 8'h08
`define P23G_ADDR_PB_DIR 8'h0C
`define P23G_ADDR_PB_DATA 8'h10
`define P23G_ADDR_SER_CFG 8'h14

`define P23G_PA_W 5
`define P23G_PB_W 8
`define P23G_REG_W 8

`define P23G_PA_DATA_RSV_ONES 8'hE0
`define P23G_DRIVE_FIXED 8'h07
`define P23G_DRIVE_OD_LSB 3
`define P23G_DRIVE_OD_W 2
`define P23G_SER_CFG_W 5

`define P23G_CFG_TX_SEL 0
`define P23G_CFG_RX_ON 1
`define P23G_CFG_CLK_HI 2
`define P23G_CFG_CLK_LO 3
`define P23G_CFG_SYNC 4

`define P23G_PIN_SCK 0
`define P23G_PIN_RX 1
`define P23G_PIN_TX 2

`define P23G_RST_BYTE 8'h00
`define P23G_RDATA_PAD 24'h00_0000

`endif

// ==== test/p23g_board.sv ====
// board-side model of one bank of pins
// assumes the bench supplies the outside level of every undriven pin
`timescale 1ns/100ps
`default_nettype none

module p23g_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] out, // block output values
  input wire logic [W-1:0] oe, // block output enables
  input wire logic [W-1:0] ext, // outside source level
  output logic [W-1:0] lvl // resolved pin level
);
  // a driving block wins; the outside source only shows where the driver is off
  assign lvl = (oe & out) | (~oe & ext);
endmodule

`default_nettype wire

// ==== test/p23g_gpio_monitor.sv ====
// concurrent checks on the top ports of the two-port gpio block
// assumes one clock domain and the register map of p23g_regs.svh
`timescale 1ns/100ps
`default_nettype none
`include "p23g_regs.svh"

module p23g_gpio_mon #(
  parameter int PA_W = 5,
  parameter int PB_W = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic ce, // enable
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [`P23G_ADDR_W-1:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic [PA_W-1:0] pa_pin_out, // port a out
  input wire logic [PA_W-1:0] pa_pin_oe, // port a oe
  input wire logic [PB_W-1:0] pb_pin_out, // port b out
  input wire logic [PB_W-1:0] pb_pin_oe, // port b oe
  input wire logic ser_tx_data, // tx data
  input wire logic ser_clk_out, // clock out
  input wire logic ser_rx_on, // rx on
  input wire logic ser_clk_source_hi, // clock in
  input wire logic ser_clk_source_lo, // clock out sel
  input wire logic ser_sync_mode, // sync
  input wire logic ser_tx_sel // tx sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_setup = psel & ~penable & ~pwrite & ce;
  wire wr_done = psel & penable & pwrite & pready;
  wire wr_pbd = wr_done & (paddr == `P23G_ADDR_PB_DATA);
  wire wr_pbc = wr_done & (paddr == `P23G_ADDR_PB_DIR);
  drv_rsv_a:
  assert property (rd_setup && paddr == `P23G_ADDR_PA_DRIVE |=> pready && prdata[7:5] == 3'b000
    && prdata[2:0] == 3'b111) else $error("drive reserved bits wrong");
  dir_wo_a:
  assert property (rd_setup && (paddr == `P23G_ADDR_PA_DIR || paddr == `P23G_ADDR_PB_DIR)
    |=> prdata == 32'h0000_0000) else $error("direction read not zero");
  rx_pin_a:
  assert property (ser_rx_on && ce |=> !pa_pin_oe[1]) else $error("rx pin driven");
  tx_pin_a:
  assert property (ser_tx_sel && ce |=> pa_pin_oe[2] && pa_pin_out[2] == $past(ser_tx_data))
    else $error("tx pin wrong");
  clk_in_a:
  assert property (ser_clk_source_hi && ce |=> !pa_pin_oe[0]) else $error("clock input driven");
  clk_out_a:
  assert property (ce && !ser_clk_source_hi && (ser_clk_source_lo || ser_sync_mode)
    |=> pa_pin_oe[0] && pa_pin_out[0] == $past(ser_clk_out)) else $error("clock output wrong");
  pb_data_a:
  assert property (!$stable(pb_pin_out) |-> $past(wr_pbd, 2)) else $error("port b out moved");
  pb_dir_a:
  assert property (!$stable(pb_pin_oe) |-> $past(wr_pbc, 2)) else $error("port b oe moved");
endmodule

bind p23g_gpio p23g_gpio_mon #(.PA_W(PA_W), .PB_W(PB_W)) mon (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pa_pin_out, .pa_pin_oe, .pb_pin_out, .pb_pin_oe, .ser_tx_data,
  .ser_clk_out, .ser_rx_on, .ser_clk_source_hi, .ser_clk_source_lo, .ser_sync_mode, .ser_tx_sel);

`default_nettype wire

// ==== test/p23g_gpio_tb_top.sv ====
// self-checking bench of the two-port gpio block against an integer model
// assumes the board models resolve pin levels; ce stays high throughout
`timescale 1ns/100ps
`default_nettype none
`include "p23g_regs.svh"

module p23g_gpio_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx = 0, ck = 0;
  logic [7:0] paddr = 8'h00, ext_b = 8'h00;
  logic [4:0] ext_a = 5'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, ser_rx_data, ser_clk_in, rx_on, c_hi, c_lo, sync, tx_sel;
  wire [4:0] pa_pin_out, pa_pin_oe, pa_lvl;
  wire [7:0] pb_pin_out, pb_pin_oe, pb_lvl;
  int err_total = 0, check_count = 0, cyc = 0;
  int m_pad, m_pat, m_drv, m_pbd, m_pbt, m_cfg;
  int exp_q[$];
  always #20 pclk = ~pclk;
  p23g_gpio dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pa_pin_in(pa_lvl), .pa_pin_out, .pa_pin_oe, .pb_pin_in(pb_lvl), .pb_pin_out,
    .pb_pin_oe, .ser_tx_data(tx), .ser_clk_out(ck), .ser_rx_data, .ser_clk_in, .ser_rx_on(rx_on),
    .ser_clk_source_hi(c_hi), .ser_clk_source_lo(c_lo), .ser_sync_mode(sync), .ser_tx_sel(tx_sel));
  p23g_board #(.W(5)) pa_board (.out(pa_pin_out), .oe(pa_pin_oe), .ext(ext_a), .lvl(pa_lvl));
  p23g_board #(.W(8)) pb_board (.out(pb_pin_out), .oe(pb_pin_oe), .ext(ext_b), .lvl(pb_lvl));

  task tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h exp %h", $time, seen, exp);
    end
  endtask
  function int a_oe();
    int oe;
    oe = m_pad & ~(m_drv & m_pat);
    if (m_cfg & 1) oe |= 4;
    if (m_cfg & 2) oe &= ~2;
    if (m_cfg & 4) oe &= ~1;
    else if (m_cfg & 'h18) oe |= 1;
    return oe;
  endfunction
  function int a_out();
    int o;
    o = m_pat;
    if (m_cfg & 1) o = (o & ~4) | (int'(tx) << 2);
    if (!(m_cfg & 4) && (m_cfg & 'h18)) o = (o & ~1) | int'(ck);
    return o;
  endfunction
  function int la();
    return ((a_oe() & a_out()) | (~a_oe() & int'(ext_a))) & 'h1f;
  endfunction
  function int e_rd(int a);
    case (a)
      `P23G_ADDR_PA_DATA: return 'he0 | (m_pad & m_pat) | (~m_pad & la());
      `P23G_ADDR_PA_DRIVE: return m_drv | 7;
      `P23G_ADDR_PB_DATA: return (m_pbd & m_pbt) | (~m_pbd & int'(ext_b) & 'hff);
      `P23G_ADDR_SER_CFG: return m_cfg;
      default: return 0;
    endcase
  endfunction
  task xfer(input int a, input logic w, input int d, output logic [31:0] r);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a[7:0], d[31:0]};
    @(posedge pclk);
    penable <= 1;
    // no local limit: only the bench timeout ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(pslverr, a > 20);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // reset everywhere, then every register read once
  task rst_chk();
    logic [31:0] r;
    {m_pad, m_pat, m_drv, m_pbd, m_pbt, m_cfg} = '0;
    for (int a = 0; a < 28; a += 4) begin
      xfer(a, 0, 0, r);
      chk(r, e_rd(a));
    end
    chk({pa_pin_oe, pb_pin_oe}, 0);
  endtask
  task step();
    logic [31:0] r;
    int a, d;
    a = ($urandom % 7) * 4;
    d = $urandom;
    xfer(a, 1, d, r);
    case (a)
      `P23G_ADDR_PA_DIR: m_pad = d & 'h1f;
      `P23G_ADDR_PA_DATA: m_pat = d & 'h1f;
      `P23G_ADDR_PA_DRIVE: m_drv = d & 'h18;
      `P23G_ADDR_PB_DIR: m_pbd = d & 'hff;
      `P23G_ADDR_PB_DATA: m_pbt = d & 'hff;
      `P23G_ADDR_SER_CFG: m_cfg = d & 'h1f;
      default: ;
    endcase
    {ext_a, ext_b, tx, ck} <= 15'($urandom);
    repeat (4) @(posedge pclk);
    chk(pa_pin_oe, a_oe());
    chk(pa_pin_out & a_oe(), a_out() & a_oe());
    chk(pb_pin_oe, m_pbd);
    chk(pb_pin_out & m_pbd, m_pbt & m_pbd);
    chk({sync, c_lo, c_hi, rx_on, tx_sel}, m_cfg);
    chk({ser_rx_data, ser_clk_in}, la() & 3);
    a = ($urandom % 7) * 4;
    exp_q.push_back(e_rd(a));
    xfer(a, 0, 0, r);
    chk(r, exp_q.pop_front());
  endtask
  initial begin
    void'($urandom(73));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rst_chk();
    repeat (300) step();
    @(posedge pclk);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rst_chk();
    tally_and_finish();
  end
endmodule

`default_nettype wire
